// >>> ptp_regs_map.svh
`ifndef PTP_REGS_MAP_SVH
`define PTP_REGS_MAP_SVH

// Register addresses and page numbers.
`define PAGE_SEL_ADDR      5'h13
`define TRIG_CFG_ADDR      5'h14
`define EV_STATUS_ADDR     5'h1e
`define EV_DATA_ADDR       5'h1f
`define PAGE_EVENTS        3'h4
`define PAGE_CONFIG        3'h5
`define PAGE_RESET         3'h0

// Trigger configuration port fields.
`define CONFIG_COMMIT_STROBE_BIT        0
`define OUTPUT_UNIT_INDEX_LSB       1
`define OUTPUT_UNIT_INDEX_MSB       3
`define TRIG_INV_BIT       7
`define TRIG_PIN_LSB       8
`define TRIG_PIN_MSB       11
`define COMPLETION_REPORT_ENABLE_BIT    12
`define TRIG_LATE_BIT      13
`define OUTPUT_REPEAT_MODE_BIT       14
`define OUTPUT_PULSE_MODE_BIT     15
`define TRIG_PIN_MAX       4'hc

// Stored trigger settings: {pulse, per, late, notify, pin[3:0], invert}.
`define CFG_W              9
`define CFG_INV            0
`define CFG_PIN_LSB        1
`define CFG_PIN_MSB        4
`define CFG_NOTIFY         5
`define CFG_LATE           6
`define CFG_PER            7
`define CFG_PULSE          8

// Event status fields, held as the low bits of a queue entry.
`define ES_DET_BIT         0
`define ES_MULT_BIT        1
`define ES_NUM_LSB         2
`define ES_NUM_MSB         4
`define ES_RF_BIT          5
`define ES_LEN_LSB         6
`define ES_LEN_MSB         7
`define ES_MISS_LSB        8
`define ES_MISS_MSB        10
`define ES_W               11
`define MISSED_MAX         3'h7

// Queue entry layout: {sec, ns, ext, status}.
`define ENT_EXT_LSB        11
`define ENT_EXT_MSB        26
`define ENT_NS_LSB         27
`define ENT_NS_MSB         56
`define ENT_SEC_LSB        57
`define ENT_SEC_MSB        88
`define ENT_W              89

`define WORD_ZERO          16'h0000
`endif

// >>> ptp_regs_pkg.sv
package ptp_regs_pkg;
  typedef logic [15:0] reg_word_t;
  typedef enum logic [2:0] {
    PH_EXT,
    PH_NS_LO,
    PH_NS_HI,
    PH_SEC_LO,
    PH_SEC_HI,
    PH_DONE
  } rd_phase_t;
endpackage : ptp_regs_pkg

// >>> event_queue.sv
`timescale 1ns/100ps
`default_nettype none
module event_queue
  import ptp_regs_pkg::*;
#(
  parameter int WIDTH = 89,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head_data,
  output logic                  empty,
  output logic                  full
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             do_push;
  logic             do_pop;

  assign empty     = (count_ff == '0);
  assign full      = (count_ff == (AW+1)'(DEPTH));
  assign do_push   = push && !full;
  assign do_pop    = pop && !empty;
  assign head_data = mem_ff[rd_ptr_ff];

  always_ff @(posedge clock)
  begin
    if (do_push)
    begin
      mem_ff[wr_ptr_ff] <= push_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      if (do_pop)
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      if (do_push && !do_pop)
        count_ff <= count_ff + 1'b1;
      else if (do_pop && !do_push)
        count_ff <= count_ff - 1'b1;
    end
  end
endmodule : event_queue
`default_nettype wire

// >>> trigger_config_store.sv
`timescale 1ns/100ps
`default_nettype none
module trigger_config_store
  import ptp_regs_pkg::*;
#(
  parameter int NUM   = 8,
  parameter int CFG_W = 9
) (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   wr_en,
  input  wire logic [$clog2(NUM)-1:0] wr_idx,
  input  wire logic [CFG_W-1:0]       wr_cfg,
  input  wire logic [$clog2(NUM)-1:0] rd_idx,
  output logic      [CFG_W-1:0]       rd_cfg,
  output logic      [NUM*CFG_W-1:0]   all_cfg
);
  logic [CFG_W-1:0] cfg_ff [NUM];

  // Each trigger keeps its settings until a write with the commit strobe set targets it.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM; i++)
        cfg_ff[i] <= '0;
    end
    else if (wr_en)
    begin
      cfg_ff[wr_idx] <= wr_cfg;
    end
  end

  assign rd_cfg = cfg_ff[rd_idx];

  always_comb
  begin
    for (int i = 0; i < NUM; i++)
      all_cfg[i*CFG_W +: CFG_W] = cfg_ff[i];
  end
endmodule : trigger_config_store
`default_nettype wire

// >>> ptp_event_readout_trigger_config.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptp_regs_map.svh"
module ptp_event_readout_trigger_config
  import ptp_regs_pkg::*;
#(
  parameter int NUM_TRIG  = 8,
  parameter int NUM_UNITS = 8,
  parameter int Q_DEPTH   = 8
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  reg_rd,
  input  wire logic                  reg_wr,
  input  wire logic [4:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  output logic      [15:0]           rd_data_ff,
  output logic                       rd_valid_ff,
  output logic      [2:0]            page_ff,
  input  wire logic                  cap_valid,
  input  wire logic [NUM_UNITS-1:0]  cap_detected,
  input  wire logic [NUM_UNITS-1:0]  cap_rising,
  input  wire logic [29:0]           cap_ns,
  input  wire logic [31:0]           cap_sec,
  output logic                       event_pending_ff,
  output logic      [NUM_TRIG-1:0]   output_pulse_mode_ff,
  output logic      [NUM_TRIG-1:0]   output_repeat_mode_ff,
  output logic      [NUM_TRIG-1:0]   fire_when_overdue_ff,
  output logic      [NUM_TRIG-1:0]   completion_report_enable_ff,
  output logic      [NUM_TRIG-1:0]   late_report_enable_ff,
  output logic      [NUM_TRIG-1:0]   output_invert_mode_ff,
  output logic      [NUM_TRIG*4-1:0] output_pin_route_ff,
  output logic      [NUM_TRIG-1:0]   config_updated_ff
);
  localparam int SW = $clog2(NUM_TRIG);
  localparam int UW = $clog2(NUM_UNITS);

  // Lowest unit index that captured an edge.
  function automatic logic [UW-1:0] lowest_unit(
    input logic [NUM_UNITS-1:0] mask
  );
    logic [UW-1:0] idx;
    idx = '0;
    for (int i = NUM_UNITS - 1; i >= 0; i--)
      if (mask[i])
        idx = UW'(i);
    return idx;
  endfunction : lowest_unit

  function automatic logic several_set(input logic [NUM_UNITS-1:0] mask);
    return (mask & (mask - 1'b1)) != '0;
  endfunction : several_set

  // Interleave detect and direction: bit 2n detect, bit 2n+1 direction.
  function automatic logic [15:0] interleave(
    input logic [NUM_UNITS-1:0] det,
    input logic [NUM_UNITS-1:0] rise
  );
    logic [15:0] w;
    w = `WORD_ZERO;
    for (int n = 0; n < NUM_UNITS; n++)
    begin
      w[2*n]   = det[n];
      w[2*n+1] = det[n] & rise[n];
    end
    return w;
  endfunction : interleave

  // Highest differing 16-bit word index against the previous capture.
  function automatic logic [1:0] changed_words(
    input logic [29:0] ns_new,
    input logic [31:0] sec_new,
    input logic [29:0] ns_old,
    input logic [31:0] sec_old
  );
    logic [1:0] len;
    len = 2'h0;
    if (sec_new[31:16] != sec_old[31:16])
      len = 2'h3;
    else if (sec_new[15:0] != sec_old[15:0])
      len = 2'h2;
    else if (ns_new[29:16] != ns_old[29:16])
      len = 2'h1;
    return len;
  endfunction : changed_words

  logic                  addr_ev_status;
  logic                  addr_ev_data;
  logic                  addr_trig;
  logic                  status_read;
  logic                  data_read;
  logic [`ENT_W-1:0]     head;
  logic [`ENT_W-1:0]     nxt_entry;
  logic                  q_empty;
  logic                  q_full;
  logic                  q_push;
  logic [2:0]            missed_ff;
  logic [29:0]           last_ns_ff;
  logic [31:0]           last_sec_ff;
  logic [`ES_W-1:0]      nxt_status;
  logic [UW-1:0]         first_unit;
  logic [`ES_W-1:0]      cur_sts_ff;
  logic [15:0]           cur_ext_ff;
  logic [29:0]           cur_ns_ff;
  logic [31:0]           cur_sec_ff;
  rd_phase_t             phase_ff;
  logic [15:0]           ev_word;
  logic [SW-1:0]         output_unit_index_ff;
  logic                  trig_write;
  logic [`CFG_W-1:0]     nxt_cfg;
  logic [`CFG_W-1:0]     sel_cfg;
  logic [NUM_TRIG*`CFG_W-1:0] all_cfg;
  logic [15:0]           nxt_rd_data;

  assign addr_ev_status = (page_ff == `PAGE_EVENTS) &&
                          (reg_addr == `EV_STATUS_ADDR);
  assign addr_ev_data   = (page_ff == `PAGE_EVENTS) &&
                          (reg_addr == `EV_DATA_ADDR);
  // Trigger configuration is decoded only on its own page.
  assign addr_trig      = (page_ff == `PAGE_CONFIG) &&
                          (reg_addr == `TRIG_CFG_ADDR);
  assign status_read    = reg_rd && addr_ev_status;
  assign data_read      = reg_rd && addr_ev_data;

  always_ff @(posedge clock)
  begin
    if (rst)
      page_ff <= `PAGE_RESET;
    else if (reg_wr && reg_addr == `PAGE_SEL_ADDR)
      page_ff <= reg_wdata[2:0];
  end

  // Capture side: build one queue entry per capture instant.
  assign first_unit = lowest_unit(cap_detected);
  assign q_push     = cap_valid && (cap_detected != '0);

  always_comb
  begin
    nxt_status = '0;
    nxt_status[`ES_DET_BIT] = 1'b1;
    nxt_status[`ES_MULT_BIT] = several_set(cap_detected);
    nxt_status[`ES_NUM_MSB:`ES_NUM_LSB] = 3'(first_unit);
    nxt_status[`ES_RF_BIT] = cap_rising[first_unit];
    nxt_status[`ES_LEN_MSB:`ES_LEN_LSB] =
      changed_words(cap_ns, cap_sec, last_ns_ff, last_sec_ff);
    nxt_status[`ES_MISS_MSB:`ES_MISS_LSB] = missed_ff;
  end

  assign nxt_entry = {cap_sec, cap_ns,
                      interleave(cap_detected, cap_rising),
                      nxt_status};

  // The length field compares against the previous queued capture, so a
  // dropped capture does not move the reference point.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      last_ns_ff  <= '0;
      last_sec_ff <= '0;
    end
    else if (q_push && !q_full)
    begin
      last_ns_ff  <= cap_ns;
      last_sec_ff <= cap_sec;
    end
  end

  // Captures lost to a full queue are counted into the next stored entry.
  always_ff @(posedge clock)
  begin
    if (rst)
      missed_ff <= '0;
    else if (q_push && q_full)
      missed_ff <= (missed_ff == `MISSED_MAX) ? missed_ff : missed_ff + 1'b1;
    else if (q_push)
      missed_ff <= '0;
  end

  event_queue #(
    .WIDTH (`ENT_W),
    .DEPTH (Q_DEPTH)
  ) u_queue (
    .clock     (clock),
    .rst       (rst),
    .push      (q_push),
    .push_data (nxt_entry),
    .pop       (status_read),
    .head_data (head),
    .empty     (q_empty),
    .full      (q_full)
  );

  // Status read loads the head event into the readout registers.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cur_sts_ff <= '0;
      cur_ns_ff  <= '0;
      cur_sec_ff <= '0;
    end
    else if (status_read)
    begin
      cur_sts_ff <= q_empty ? '0 : head[`ES_W-1:0];
      cur_ns_ff  <= head[`ENT_NS_MSB:`ENT_NS_LSB];
      cur_sec_ff <= head[`ENT_SEC_MSB:`ENT_SEC_LSB];
    end
  end

  // Extended word clears once it has been read out.
  always_ff @(posedge clock)
  begin
    if (rst)
      cur_ext_ff <= `WORD_ZERO;
    else if (status_read)
      cur_ext_ff <= q_empty ? `WORD_ZERO : head[`ENT_EXT_MSB:`ENT_EXT_LSB];
    else if (data_read && phase_ff == PH_EXT)
      cur_ext_ff <= `WORD_ZERO;
  end

  // Read sequencer; stopping early is harmless since the next status read
  // restarts it.
  always_ff @(posedge clock)
  begin
    if (rst)
      phase_ff <= PH_DONE;
    else if (status_read)
    begin
      if (!q_empty && head[`ES_MULT_BIT])
        phase_ff <= PH_EXT;
      else if (!q_empty)
        phase_ff <= PH_NS_LO;
      else
        phase_ff <= PH_DONE;
    end
    else if (data_read)
    begin
      case (phase_ff)
        PH_EXT:    phase_ff <= PH_NS_LO;
        PH_NS_LO:  phase_ff <= PH_NS_HI;
        PH_NS_HI:  phase_ff <= PH_SEC_LO;
        PH_SEC_LO: phase_ff <= PH_SEC_HI;
        PH_SEC_HI: phase_ff <= PH_DONE;
        default:   phase_ff <= PH_DONE;
      endcase
    end
  end

  always_comb
  begin
    ev_word = `WORD_ZERO;
    if (cur_sts_ff[`ES_DET_BIT])
    begin
      case (phase_ff)
        PH_EXT:    ev_word = cur_ext_ff;
        PH_NS_LO:  ev_word = cur_ns_ff[15:0];
        PH_NS_HI:  ev_word = {2'b00, cur_ns_ff[29:16]};
        PH_SEC_LO: ev_word = cur_sec_ff[15:0];
        PH_SEC_HI: ev_word = cur_sec_ff[31:16];
        default:   ev_word = `WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      event_pending_ff <= 1'b0;
    else
      event_pending_ff <= !q_empty;
  end

  // Trigger configuration port.
  assign trig_write = reg_wr && addr_trig;

  always_comb
  begin
    nxt_cfg = '0;
    nxt_cfg[`CFG_PULSE]  = reg_wdata[`OUTPUT_PULSE_MODE_BIT];
    nxt_cfg[`CFG_PER]    = reg_wdata[`OUTPUT_REPEAT_MODE_BIT];
    nxt_cfg[`CFG_LATE]   = reg_wdata[`TRIG_LATE_BIT];
    nxt_cfg[`CFG_NOTIFY] = reg_wdata[`COMPLETION_REPORT_ENABLE_BIT];
    nxt_cfg[`CFG_PIN_MSB:`CFG_PIN_LSB] =
      reg_wdata[`TRIG_PIN_MSB:`TRIG_PIN_LSB];
    nxt_cfg[`CFG_INV]    = reg_wdata[`TRIG_INV_BIT];
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      output_unit_index_ff <= '0;
    else if (trig_write)
      output_unit_index_ff <= SW'(reg_wdata[`OUTPUT_UNIT_INDEX_MSB:`OUTPUT_UNIT_INDEX_LSB]);
  end

  trigger_config_store #(
    .NUM   (NUM_TRIG),
    .CFG_W (`CFG_W)
  ) u_store (
    .clock   (clock),
    .rst     (rst),
    .wr_en   (trig_write && reg_wdata[`CONFIG_COMMIT_STROBE_BIT]),
    .wr_idx  (SW'(reg_wdata[`OUTPUT_UNIT_INDEX_MSB:`OUTPUT_UNIT_INDEX_LSB])),
    .wr_cfg  (nxt_cfg),
    .rd_idx  (output_unit_index_ff),
    .rd_cfg  (sel_cfg),
    .all_cfg (all_cfg)
  );

  // Per-trigger settings toward the trigger engine, two cycles after a write.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      output_pulse_mode_ff        <= '0;
      output_repeat_mode_ff       <= '0;
      fire_when_overdue_ff        <= '0;
      completion_report_enable_ff <= '0;
      late_report_enable_ff       <= '0;
      output_invert_mode_ff       <= '0;
      output_pin_route_ff         <= '0;
    end
    else
    begin
      for (int t = 0; t < NUM_TRIG; t++)
      begin
        output_pulse_mode_ff[t] <=
          all_cfg[t*`CFG_W + `CFG_PULSE];
        output_repeat_mode_ff[t] <=
          all_cfg[t*`CFG_W + `CFG_PER];
        fire_when_overdue_ff[t] <=
          all_cfg[t*`CFG_W + `CFG_LATE];
        completion_report_enable_ff[t] <=
          all_cfg[t*`CFG_W + `CFG_NOTIFY];
        late_report_enable_ff[t] <=
          all_cfg[t*`CFG_W + `CFG_NOTIFY] &&
          !(all_cfg[t*`CFG_W + `CFG_PER] &&
            all_cfg[t*`CFG_W + `CFG_LATE]);
        output_invert_mode_ff[t] <=
          all_cfg[t*`CFG_W + `CFG_INV];
        // Out-of-range pin codes are treated as unconnected.
        output_pin_route_ff[t*4 +: 4] <=
          (all_cfg[t*`CFG_W + `CFG_PIN_LSB +: 4] > `TRIG_PIN_MAX) ?
          4'h0 : all_cfg[t*`CFG_W + `CFG_PIN_LSB +: 4];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      config_updated_ff <= '0;
    else
    begin
      config_updated_ff <= '0;
      if (trig_write && reg_wdata[`CONFIG_COMMIT_STROBE_BIT])
        config_updated_ff[reg_wdata[`OUTPUT_UNIT_INDEX_MSB:`OUTPUT_UNIT_INDEX_LSB]] <= 1'b1;
    end
  end

  // Read mux; page select reads back on every page, other unmapped addresses and pages return zero.
  always_comb
  begin
    nxt_rd_data = `WORD_ZERO;
    if (reg_addr == `PAGE_SEL_ADDR)
      nxt_rd_data = {13'h0000, page_ff};
    else if (addr_ev_status)
      nxt_rd_data = q_empty ? `WORD_ZERO : 16'(head[`ES_W-1:0]);
    else if (addr_ev_data)
      nxt_rd_data = ev_word;
    else if (addr_trig)
    begin
      nxt_rd_data[`OUTPUT_PULSE_MODE_BIT]  = sel_cfg[`CFG_PULSE];
      nxt_rd_data[`OUTPUT_REPEAT_MODE_BIT]    = sel_cfg[`CFG_PER];
      nxt_rd_data[`TRIG_LATE_BIT]   = sel_cfg[`CFG_LATE];
      nxt_rd_data[`COMPLETION_REPORT_ENABLE_BIT] = sel_cfg[`CFG_NOTIFY];
      nxt_rd_data[`TRIG_PIN_MSB:`TRIG_PIN_LSB] =
        sel_cfg[`CFG_PIN_MSB:`CFG_PIN_LSB];
      nxt_rd_data[`TRIG_INV_BIT]    = sel_cfg[`CFG_INV];
      nxt_rd_data[`OUTPUT_UNIT_INDEX_MSB:`OUTPUT_UNIT_INDEX_LSB] = 3'(output_unit_index_ff);
      nxt_rd_data[`CONFIG_COMMIT_STROBE_BIT]     = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rd_data_ff  <= `WORD_ZERO;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= reg_rd;
      if (reg_rd)
        rd_data_ff <= nxt_rd_data;
    end
  end
endmodule : ptp_event_readout_trigger_config
`default_nettype wire

// >>> ptp_event_readout_trigger_config_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptp_regs_map.svh"
module ptp_event_readout_trigger_config_checker
  import ptp_regs_pkg::*;
#(
  parameter int NUM_TRIG = 8
) (
  input wire logic                  clock,
  input wire logic                  rst,
  input wire logic                  reg_rd,
  input wire logic                  reg_wr,
  input wire logic [4:0]            reg_addr,
  input wire logic [15:0]           reg_wdata,
  input wire logic [15:0]           rd_data_ff,
  input wire logic                  rd_valid_ff,
  input wire logic [2:0]            page_ff,
  input wire logic                  event_pending_ff,
  input wire logic [NUM_TRIG-1:0]   output_pulse_mode_ff,
  input wire logic [NUM_TRIG-1:0]   output_repeat_mode_ff,
  input wire logic [NUM_TRIG-1:0]   fire_when_overdue_ff,
  input wire logic [NUM_TRIG-1:0]   completion_report_enable_ff,
  input wire logic [NUM_TRIG-1:0]   late_report_enable_ff,
  input wire logic [NUM_TRIG-1:0]   output_invert_mode_ff,
  input wire logic [NUM_TRIG*4-1:0] output_pin_route_ff,
  input wire logic [NUM_TRIG-1:0]   config_updated_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic cfg_sel;
  logic cfg_wr;
  logic st_rd;
  assign cfg_sel = reg_addr == `TRIG_CFG_ADDR && page_ff == `PAGE_CONFIG;
  assign cfg_wr = reg_wr && cfg_sel && reg_wdata[0];
  assign st_rd = reg_rd && reg_addr == `EV_STATUS_ADDR
                 && page_ff == `PAGE_EVENTS;

  property p_rd_valid;
    1'b1 |=> rd_valid_ff == $past(reg_rd);
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read answer not one cycle after request");
  property p_reserved_zero;
    reg_rd && cfg_sel |=> rd_data_ff[6:4] == 3'b000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved trigger bits read non-zero");
  property p_commit_zero;
    reg_rd && cfg_sel |=> !rd_data_ff[0];
  endproperty
  a_commit_zero: assert property (p_commit_zero)
    else $error("commit strobe read back as one");
  // The update pulse rises on the same edge that stores the settings.
  property p_commit_pulse;
    cfg_wr |-> ##1 $onehot(config_updated_ff)
      && config_updated_ff[$past(reg_wdata[3:1])];
  endproperty
  a_commit_pulse: assert property (p_commit_pulse)
    else $error("commit did not update the selected trigger");
  property p_settings;
    logic [15:0] w;
    (cfg_wr, w = reg_wdata) |-> ##2
      output_pulse_mode_ff[w[3:1]] == w[15]
      && output_repeat_mode_ff[w[3:1]] == w[14]
      && fire_when_overdue_ff[w[3:1]] == w[13];
  endproperty
  a_settings: assert property (p_settings)
    else $error("trigger mode bits differ from committed word");
  property p_report;
    logic [15:0] w;
    (cfg_wr, w = reg_wdata) |-> ##2
      completion_report_enable_ff[w[3:1]] == w[12]
      && output_invert_mode_ff[w[3:1]] == w[7];
  endproperty
  a_report: assert property (p_report)
    else $error("trigger report or invert bit differs from committed word");
  property p_pin;
    logic [15:0] w;
    (cfg_wr, w = reg_wdata) |-> ##2 output_pin_route_ff[w[3:1]*4 +: 4]
      == (w[11:8] > `TRIG_PIN_MAX ? 4'h0 : w[11:8]);
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin route differs from committed field");
  property p_late;
    1'b1 |-> late_report_enable_ff == (completion_report_enable_ff
      & ~(output_repeat_mode_ff & fire_when_overdue_ff));
  endproperty
  a_late: assert property (p_late)
    else $error("late report enable inconsistent");
  property p_status_pop;
    st_rd && event_pending_ff && !$past(st_rd)
      |=> rd_data_ff[0] && rd_data_ff[15:11] == 5'h0;
  endproperty
  a_status_pop: assert property (p_status_pop)
    else $error("pending event gave empty status");
  property p_page;
    reg_wr && reg_addr == `PAGE_SEL_ADDR |=> page_ff == $past(reg_wdata[2:0]);
  endproperty
  a_page: assert property (p_page)
    else $error("page select not taken");
endmodule : ptp_event_readout_trigger_config_checker
`default_nettype wire

// >>> ptp_event_readout_trigger_config_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module ptp_event_readout_trigger_config_tb_top;
  import ptp_regs_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        reg_rd = 1'b0;
  logic        reg_wr = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        cap_valid = 1'b0;
  logic [7:0]  cap_detected = 8'h00;
  logic [7:0]  cap_rising = 8'h00;
  logic [29:0] cap_ns = 30'h0;
  logic [31:0] cap_sec = 32'h0;
  logic [15:0] rd_data_ff;
  logic        rd_valid_ff;
  logic [2:0]  page_ff;
  logic        event_pending_ff;
  logic [7:0]  pulse, rpt, late, notify, lrep, inv, upd;
  logic [31:0] pin;
  int          n_fail = 0;
  int          samples_checked = 0;

  always #2.5 clock = ~clock;

  ptp_event_readout_trigger_config ptp_event_readout_trigger_config_inst (
    .clock(clock), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .rd_data_ff(rd_data_ff),
    .rd_valid_ff(rd_valid_ff), .page_ff(page_ff), .cap_valid(cap_valid),
    .cap_detected(cap_detected), .cap_rising(cap_rising), .cap_ns(cap_ns),
    .cap_sec(cap_sec), .event_pending_ff(event_pending_ff),
    .output_pulse_mode_ff(pulse), .output_repeat_mode_ff(rpt),
    .fire_when_overdue_ff(late), .completion_report_enable_ff(notify),
    .late_report_enable_ff(lrep), .output_invert_mode_ff(inv),
    .output_pin_route_ff(pin), .config_updated_ff(upd));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr

  // The answer is due exactly one cycle after the request edge.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    check(32'(rd_valid_ff), 32'h1);
    d = rd_data_ff;
  endtask : rd

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic t_trigger;
    logic [15:0] d;
    check({page_ff, pulse, pin[7:0], 1'b0, event_pending_ff}, 32'h0);
    wr(5'h13, 16'h0005);
    check(32'(page_ff), 32'h5);
    wr(5'h14, 16'hf5f7);
    // The update pulse stands only in the cycle right after the write.
    check(32'(upd), 32'h8);
    repeat (2) @(negedge clock);
    check(32'({pulse, rpt}), 32'h0808);
    check(32'({late, notify}), 32'h0808);
    check(32'({inv, upd}), 32'h0800);
    check(32'(pin[15:12]), 32'h5);
    check(32'(lrep), 32'h0);
    wr(5'h14, 16'h1d0d);
    check(32'(upd), 32'h40);
    repeat (2) @(negedge clock);
    check(32'({pin[27:24], pin[15:12]}), 32'h05);
    check(32'({lrep, upd}), 32'h4000);
    wr(5'h14, 16'h0006);
    rd(5'h14, d);
    check(32'(d), 32'hf586);
    wr(5'h14, 16'h000c);
    rd(5'h14, d);
    check(32'(d), 32'h1d0c);
    rd(5'h1e, d);
    check(32'(d), 32'h0);
    $display("t_trigger done");
  endtask : t_trigger

  task automatic cap(input logic [7:0] det, input logic [7:0] rise,
                     input logic [29:0] ns);
    @(negedge clock);
    cap_valid = 1'b1;
    cap_detected = det;
    cap_rising = rise;
    cap_ns = ns;
    cap_sec = 32'h1234_5678;
    @(negedge clock);
    cap_valid = 1'b0;
  endtask : cap

  task automatic t_events;
    logic [15:0] d;
    int i;
    wr(5'h13, 16'h0004);
    cap(8'h24, 8'h20, 30'h2bcd_1234);
    cap(8'h01, 8'h01, 30'h2bcd_9999);
    for (i = 0; i < 20 && event_pending_ff !== 1'b1; i++)
      @(negedge clock);
    if (event_pending_ff !== 1'b1)
    begin
      n_fail++;
      tally_and_finish;
    end
    // First capture differs from the reset reference in every word.
    rd(5'h1e, d);
    check(32'(d), 32'h00cb);
    rd(5'h1f, d);
    check(32'(d), 32'h0c10);
    rd(5'h1f, d);
    check(32'(d), 32'h1234);
    rd(5'h1f, d);
    check(32'(d), 32'h2bcd);
    rd(5'h1f, d);
    check(32'(d), 32'h5678);
    rd(5'h1f, d);
    check(32'(d), 32'h1234);
    rd(5'h1e, d);
    check(32'(d), 32'h0021);
    rd(5'h1f, d);
    check(32'(d), 32'h9999);
    rd(5'h1e, d);
    check(32'(d), 32'h0);
    rd(5'h1f, d);
    check(32'(d), 32'h0);
    $display("t_events done");
  endtask : t_events

  initial
  begin
    repeat (4) @(negedge clock);
    rst = 1'b0;
    t_trigger;
    t_events;
    tally_and_finish;
  end
endmodule : ptp_event_readout_trigger_config_tb_top

bind ptp_event_readout_trigger_config
  ptp_event_readout_trigger_config_checker #(.NUM_TRIG(NUM_TRIG)) chk_inst (
    .clock, .rst, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .rd_data_ff,
    .rd_valid_ff, .page_ff, .event_pending_ff, .output_pulse_mode_ff,
    .output_repeat_mode_ff, .fire_when_overdue_ff,
    .completion_report_enable_ff, .late_report_enable_ff,
    .output_invert_mode_ff, .output_pin_route_ff, .config_updated_ff);
`default_nettype wire
